// [outdp_top.sv]
`timescale 1ns/1ps
`default_nettype none
module outdp_top
    import outdp_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic lclk,
    input wire logic spi_sck,
    input wire logic spi_ss_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic frame_active,
    input wire logic pix_valid,
    input wire logic pix_black,
    input wire logic [NUM_LANES-1:0][WORD_W-1:0] pix_data,
    input wire logic win_id,
    output logic [NUM_LANES-1:0][WORD_W-1:0] data_word,
    output logic [WORD_W-1:0] sync_word,
    output logic [NUM_LANES-1:0][WORD_W-1:0] crc_word,
    output logic clk_out_en,
    output logic sync_en,
    output logic data_en,
    output logic win_id_out
);
    cfg_port_if cp ();

    spi_cfg_slave u_spi (
        .mclk(mclk),
        .reset(reset),
        .spi_sck(spi_sck),
        .spi_ss_n(spi_ss_n),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe),
        .cp(cp)
    );

    // register side, mclk domain
    typedef struct packed {
        logic [DATA_W-1:0] pwr;
        logic [DATA_W-1:0] blk;
        logic [DATA_W-1:0] gen;
        logic [DATA_W-1:0] train;
        logic [DATA_W-1:0] mark;
        cfg_t hold;
        logic req;
        logic ack_s1;
        logic ack_s2;
        logic dirty;
    } reg_st_t;

    // link side, lclk domain
    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic ack;
        cfg_t act;
        logic frame_q;
        logic [7:0] cnt;
        logic [NUM_LANES-1:0][16:0] sum;
        logic [NUM_LANES-1:0][11:0] off;
        logic [NUM_LANES-1:0][WORD_W-1:0] crc;
        logic [NARROW_SHIFT-1:0] win_sh;
        logic [NUM_LANES-1:0][WORD_W-1:0] dw;
        logic [WORD_W-1:0] sw;
        logic clk_en;
        logic sy_en;
        logic d_en;
        logic win_o;
    } lnk_st_t;

    reg_st_t rs_ff;
    reg_st_t nxt_rs;
    lnk_st_t ls_ff;
    lnk_st_t nxt_ls;

    function automatic logic [9:0] crc_step(input logic [9:0] c,
                                            input logic [9:0] d);
        logic [9:0] r;
        logic fb;
        r = c;
        for (int i = WORD_W - 1; i >= 0; i--) begin
            fb = r[WORD_W-1] ^ d[i];
            r = {r[WORD_W-2:0], 1'b0};
            if (fb) begin
                r = r ^ CRC_POLY;
            end
        end
        return r;
    endfunction

    // read mux; unmapped addresses read zero
    always_comb begin
        unique case (cp.addr)
            REG_SER_PWR: cp.rdata = rs_ff.pwr;
            REG_BLACK_CAL: cp.rdata = rs_ff.blk;
            REG_GEN_CFG: cp.rdata = rs_ff.gen;
            REG_IDLE_WORD: cp.rdata = rs_ff.train;
            REG_MARKER: cp.rdata = rs_ff.mark;
            default: cp.rdata = '0;
        endcase
    end

    // register writes and the config handshake toward the link
    always_comb begin
        nxt_rs = rs_ff;
        nxt_rs.ack_s1 = ls_ff.ack;
        nxt_rs.ack_s2 = rs_ff.ack_s1;
        if (cp.wr) begin
            unique case (cp.addr)
                REG_SER_PWR: nxt_rs.pwr = cp.wdata;
                REG_BLACK_CAL: nxt_rs.blk = cp.wdata;
                REG_GEN_CFG: nxt_rs.gen = cp.wdata;
                REG_IDLE_WORD: nxt_rs.train = cp.wdata;
                REG_MARKER: nxt_rs.mark = cp.wdata;
                default: nxt_rs.pwr = rs_ff.pwr;
            endcase
        end
        // set wins: a write landing with the launch re-arms dirty
        if (rs_ff.dirty && (rs_ff.req == rs_ff.ack_s2)) begin
            nxt_rs.hold.pwr_clk = rs_ff.pwr[PWR_CLK_BIT];
            nxt_rs.hold.pwr_sync = rs_ff.pwr[PWR_SYNC_BIT];
            nxt_rs.hold.pwr_data = rs_ff.pwr[PWR_DATA_BIT];
            nxt_rs.hold.target = rs_ff.blk[TGT_LSB +: 8];
            nxt_rs.hold.samples = rs_ff.blk[SMP_LSB +: 3];
            nxt_rs.hold.crc_seed = rs_ff.blk[SEED_BIT];
            nxt_rs.hold.auto_en = rs_ff.gen[AUTO_BIT];
            nxt_rs.hold.man_off = rs_ff.gen[MAN_LSB +: 9];
            nxt_rs.hold.man_dec = rs_ff.gen[DEC_BIT];
            nxt_rs.hold.narrow = rs_ff.gen[NARROW_BIT];
            nxt_rs.hold.train = rs_ff.train[TRAIN_LSB +: 10];
            nxt_rs.hold.marker = rs_ff.mark[MARK_LSB +: 7];
            nxt_rs.req = ~rs_ff.req;
            nxt_rs.dirty = 1'b0;
        end
        if (cp.wr) begin
            nxt_rs.dirty = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rs_ff <= '0;
            rs_ff.pwr <= RST_SER_PWR;
            rs_ff.blk <= RST_BLACK_CAL;
            rs_ff.gen <= RST_GEN_CFG;
            rs_ff.train <= RST_IDLE_WORD;
            rs_ff.mark <= RST_MARKER;
            rs_ff.hold <= CFG_RST;
        end else begin
            rs_ff <= nxt_rs;
        end
    end

    // link datapath: calibration, lane words, checksum, window ids
    always_comb begin
        logic signed [12:0] s;
        logic signed [11:0] eo;
        logic [11:0] m;
        logic [16:0] tot;
        logic [9:0] avg;
        logic [9:0] corr;
        logic last;
        logic fstart;
        s = '0;
        eo = '0;
        m = '0;
        tot = '0;
        avg = '0;
        corr = '0;
        last = 1'b0;
        fstart = frame_active & ~ls_ff.frame_q;
        nxt_ls = ls_ff;
        nxt_ls.req_s1 = rs_ff.req;
        nxt_ls.req_s2 = ls_ff.req_s1;
        nxt_ls.frame_q = frame_active;
        // hold is stable while the toggles differ; take it only when idle
        if ((ls_ff.req_s2 != ls_ff.ack) && !frame_active) begin
            nxt_ls.act = rs_ff.hold; // [R13]
            nxt_ls.ack = ls_ff.req_s2;
            // a smaller sample field must not strand the count above it
            nxt_ls.cnt = '0; // [R5]
        end
        last = (ls_ff.cnt == ((8'h01 << ls_ff.act.samples) - 8'h01)); // [R5]
        if (fstart) begin
            nxt_ls.cnt = '0;
        end else if (frame_active && pix_valid && pix_black
                     && ls_ff.act.auto_en) begin
            nxt_ls.cnt = last ? 8'h00 : ls_ff.cnt + 8'h01;
        end
        m = {3'b000, ls_ff.act.man_off};
        nxt_ls.sw = '0;
        if (ls_ff.act.pwr_sync) begin
            nxt_ls.sw = frame_active ? {3'b000, ls_ff.act.marker}
                                     : ls_ff.act.train; // [R2]
        end
        for (int ch = 0; ch < NUM_LANES; ch++) begin
            // black pixels feed the running sum per lane
            tot = ls_ff.sum[ch] + {7'b0000000, pix_data[ch]};
            avg = 10'(tot >> ls_ff.act.samples); // [R5]
            if (fstart) begin
                nxt_ls.sum[ch] = '0;
            end else if (frame_active && pix_valid && pix_black
                         && ls_ff.act.auto_en) begin // [R7]
                nxt_ls.sum[ch] = last ? 17'h00000 : tot;
                if (last) begin
                    nxt_ls.off[ch] = {4'h0, ls_ff.act.target}
                                     - {2'b00, avg}; // [R4]
                end
            end
            // manual offset only when auto is off, sign from dec bit
            if (ls_ff.act.auto_en) begin
                eo = ls_ff.off[ch]; // [R7]
            end else begin
                eo = ls_ff.act.man_dec ? -m : m; // [R8] [R9]
            end
            s = $signed({3'b000, pix_data[ch]}) + 13'(eo);
            if (s < 0) begin
                corr = '0;
            end else if (s > $signed({3'b000, WORD_MAX})) begin
                corr = WORD_MAX;
            end else begin
                corr = s[9:0];
            end
            if (ls_ff.act.narrow) begin
                corr = {2'b00, corr[9:2]}; // [R10]
            end
            if (!ls_ff.act.pwr_data) begin
                nxt_ls.dw[ch] = '0; // [R3]
            end else if (frame_active && pix_valid) begin
                nxt_ls.dw[ch] = corr;
            end else begin
                nxt_ls.dw[ch] = ls_ff.act.train; // [R11]
            end
            // checksum restarts from the seed at each frame start
            if (fstart) begin
                nxt_ls.crc[ch] = {WORD_W{ls_ff.act.crc_seed}}; // [R6]
            end else if (frame_active && pix_valid) begin
                nxt_ls.crc[ch] = crc_step(ls_ff.crc[ch], corr);
            end
        end
        nxt_ls.win_sh = {ls_ff.win_sh[NARROW_SHIFT-2:0], win_id};
        nxt_ls.win_o = ls_ff.act.narrow ? ls_ff.win_sh[NARROW_SHIFT-1]
                                        : win_id; // [R10]
        nxt_ls.clk_en = ls_ff.act.pwr_clk; // [R1]
        nxt_ls.sy_en = ls_ff.act.pwr_sync; // [R2]
        nxt_ls.d_en = ls_ff.act.pwr_data; // [R3]
    end

    always_ff @(posedge lclk or posedge reset) begin
        if (reset) begin
            ls_ff <= '0;
            ls_ff.act <= CFG_RST;
        end else begin
            ls_ff <= nxt_ls;
        end
    end

    assign data_word = ls_ff.dw;
    assign sync_word = ls_ff.sw;
    assign crc_word = ls_ff.crc;
    assign clk_out_en = ls_ff.clk_en;
    assign sync_en = ls_ff.sy_en;
    assign data_en = ls_ff.d_en;
    assign win_id_out = ls_ff.win_o;

    // clock driver follows its power bit one edge later
    AST_CLK_PWR: assert property ( // [R1]
        @(posedge lclk) disable iff (reset)
        clk_out_en == $past(ls_ff.act.pwr_clk))
        else $error("clock output enable does not follow power bit");

    // powered-down sync channel is silent
    AST_SYNC_OFF: assert property ( // [R2]
        @(posedge lclk) disable iff (reset)
        !ls_ff.act.pwr_sync |=> (sync_word == '0) && !sync_en)
        else $error("sync channel active while powered down");

    // all four lanes go quiet together
    AST_DATA_OFF: assert property ( // [R3]
        @(posedge lclk) disable iff (reset)
        !ls_ff.act.pwr_data |=> (data_word == '0) && !data_en)
        else $error("data lanes active while powered down");

    // auto offset equals target minus lane average at sample end
    AST_AUTO_TARGET: assert property ( // [R4]
        @(posedge lclk) disable iff (reset)
        (frame_active && ls_ff.frame_q && pix_valid && pix_black
         && ls_ff.act.auto_en && ls_ff.cnt == '0
         && ls_ff.act.samples == '0)
        |=> ls_ff.off[0] == 12'({4'h0, $past(ls_ff.act.target)}
                               - {2'b00, $past(pix_data[0])}))
        else $error("black offset not aimed at target");

    // sample counter wraps at two to the power of the field
    AST_SAMPLE_WRAP: assert property ( // [R5]
        @(posedge lclk) disable iff (reset)
        ls_ff.cnt <= ((8'h01 << ls_ff.act.samples) - 8'h01))
        else $error("sample count beyond programmed total");

    // checksum restarts from the seed
    AST_CRC_SEED: assert property ( // [R6]
        @(posedge lclk) disable iff (reset)
        (frame_active && !ls_ff.frame_q)
        |=> crc_word[0] == {WORD_W{$past(ls_ff.act.crc_seed)}})
        else $error("checksum seed wrong at frame start");

    // manual offset added while the direction bit is clear, only without auto
    AST_MANUAL_OFS: assert property ( // [R8]
        @(posedge lclk) disable iff (reset)
        (!ls_ff.act.auto_en && !ls_ff.act.narrow && ls_ff.act.pwr_data
         && frame_active && pix_valid && !ls_ff.act.man_dec
         && pix_data[0] == '0 && ls_ff.act.man_off <= 9'h0ff)
        |=> data_word[0] == {1'b0, $past(ls_ff.act.man_off)})
        else $error("manual offset not applied"); // [R9]

    // narrow mode delays window ids by four more cycles
    AST_NARROW_WIN: assert property ( // [R10]
        @(posedge lclk) disable iff (reset)
        (win_id && ls_ff.act.narrow && frame_active) ##1 frame_active[*4]
        |=> win_id_out)
        else $error("window id not delayed in narrow mode");

    // idle lanes carry the alignment word
    AST_IDLE_TRAIN: assert property ( // [R11]
        @(posedge lclk) disable iff (reset)
        (!frame_active && ls_ff.act.pwr_data)
        |=> data_word[NUM_LANES-1] == $past(ls_ff.act.train))
        else $error("idle lane not sending alignment word");

    // active config frozen while a frame runs
    AST_CFG_FROZEN: assert property ( // [R13]
        @(posedge lclk) disable iff (reset)
        frame_active |=> $stable(ls_ff.act))
        else $error("config changed inside a frame");

    // a write reaches its register on the next edge
    AST_REG_WRITE: assert property (
        @(posedge mclk) disable iff (reset)
        (cp.wr && cp.addr == REG_GEN_CFG) |=> rs_ff.gen == $past(cp.wdata))
        else $error("register write lost");
endmodule
`default_nettype wire

// [outdp_pkg.sv]
// Operation
// [R1] clock output driver runs only while its power bit 0 is set
// [R2] sync output channel runs only while its power bit 1 is set
// [R3] all four data channels run only while power bit 2 is set
// [R4] black calibration steers output black to the 8-bit target, default 8
// [R5] calibration averages two to the power of the sample field black pixels
// [R6] per-frame checksum starts from all zeros, or all ones when bit 15 set
// [R7] automatic black calibration runs when its enable is 1, reset value 1
// [R8] manual 9-bit offset applies only while automatic calibration is off
// [R9] manual offset is added when bit 10 is 0, subtracted when 1
// [R10] bit 13 picks 8-bit words and delays window ids four cycles
// [R11] idle data channels carry the programmable 10-bit alignment word
// [R12] receiver finds word boundaries from the alignment word before pixels
// [R13] software changes reach the link only between frames
package outdp_pkg;
    // register port framing
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam int SPI_HDR_LAST = 9;
    localparam int SPI_FRAME_LAST = 25;
    localparam int SPI_CNT_W = 5;

    // register addresses
    localparam logic [8:0] REG_SER_PWR = 9'h070;
    localparam logic [8:0] REG_BLACK_CAL = 9'h080;
    localparam logic [8:0] REG_GEN_CFG = 9'h081;
    localparam logic [8:0] REG_IDLE_WORD = 9'h082;
    localparam logic [8:0] REG_MARKER = 9'h083;

    // reset values
    localparam logic [15:0] RST_SER_PWR = 16'h0000;
    localparam logic [15:0] RST_BLACK_CAL = 16'h4008;
    localparam logic [15:0] RST_GEN_CFG = 16'hc001;
    localparam logic [15:0] RST_IDLE_WORD = 16'h03a6;
    localparam logic [15:0] RST_MARKER = 16'h002a;

    // field positions
    localparam int PWR_CLK_BIT = 0;
    localparam int PWR_SYNC_BIT = 1;
    localparam int PWR_DATA_BIT = 2;
    localparam int TGT_LSB = 0;
    localparam int SMP_LSB = 8;
    localparam int SEED_BIT = 15;
    localparam int AUTO_BIT = 0;
    localparam int MAN_LSB = 1;
    localparam int DEC_BIT = 10;
    localparam int NARROW_BIT = 13;
    localparam int TRAIN_LSB = 0;
    localparam int MARK_LSB = 0;

    // datapath sizes
    localparam int NUM_LANES = 4;
    localparam int WORD_W = 10;
    localparam int NARROW_SHIFT = 4;
    localparam logic [9:0] WORD_MAX = 10'h3ff;
    localparam logic [9:0] CRC_POLY = 10'h233;

    typedef struct packed {
        logic pwr_clk;
        logic pwr_sync;
        logic pwr_data;
        logic [7:0] target;
        logic [2:0] samples;
        logic crc_seed;
        logic auto_en;
        logic [8:0] man_off;
        logic man_dec;
        logic narrow;
        logic [9:0] train;
        logic [6:0] marker;
    } cfg_t;

    localparam cfg_t CFG_RST = '{
        pwr_clk: RST_SER_PWR[PWR_CLK_BIT],
        pwr_sync: RST_SER_PWR[PWR_SYNC_BIT],
        pwr_data: RST_SER_PWR[PWR_DATA_BIT],
        target: RST_BLACK_CAL[TGT_LSB +: 8],
        samples: RST_BLACK_CAL[SMP_LSB +: 3],
        crc_seed: RST_BLACK_CAL[SEED_BIT],
        auto_en: RST_GEN_CFG[AUTO_BIT],
        man_off: RST_GEN_CFG[MAN_LSB +: 9],
        man_dec: RST_GEN_CFG[DEC_BIT],
        narrow: RST_GEN_CFG[NARROW_BIT],
        train: RST_IDLE_WORD[TRAIN_LSB +: 10],
        marker: RST_MARKER[MARK_LSB +: 7]
    };
endpackage

// [cfg_port_if.sv]
`timescale 1ns/1ps
`default_nettype none
// register access strobes between the serial port and the register bank
interface cfg_port_if;
    import outdp_pkg::*;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    modport spi_end (output wr, output addr, output wdata, input rdata);
    modport reg_end (input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// [spi_cfg_slave.sv]
`timescale 1ns/1ps
`default_nettype none
module spi_cfg_slave
    import outdp_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic spi_sck,
    input wire logic spi_ss_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    cfg_port_if.spi_end cp
);
    typedef struct packed {
        logic sck_s1;
        logic sck_s2;
        logic sck_s3;
        logic ss_s1;
        logic ss_s2;
        logic mosi_s1;
        logic mosi_s2;
        logic [SPI_CNT_W-1:0] cnt;
        logic [DATA_W-1:0] shin;
        logic wbit;
        logic load;
        logic [DATA_W-1:0] shout;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic miso_oe;
    } spi_st_t;

    spi_st_t st_ff;
    spi_st_t nxt_st;
    logic rise;

    // edge taken from the second and third stages only
    assign rise = st_ff.sck_s2 & ~st_ff.sck_s3;

    // frame: 9 address bits, write bit, 16 data bits, msb first
    always_comb begin
        nxt_st = st_ff;
        nxt_st.sck_s1 = spi_sck;
        nxt_st.sck_s2 = st_ff.sck_s1;
        nxt_st.sck_s3 = st_ff.sck_s2;
        nxt_st.ss_s1 = spi_ss_n;
        nxt_st.ss_s2 = st_ff.ss_s1;
        nxt_st.mosi_s1 = spi_mosi;
        nxt_st.mosi_s2 = st_ff.mosi_s1;
        nxt_st.wr = 1'b0;
        nxt_st.load = 1'b0;
        if (st_ff.ss_s2) begin
            nxt_st.cnt = '0;
            nxt_st.miso_oe = 1'b0;
            nxt_st.shout = '0;
        end else begin
            nxt_st.miso_oe = 1'b1;
            // read data arrives one cycle after the address settles
            if (st_ff.load) begin
                nxt_st.shout = cp.rdata;
            end
            if (rise) begin
                nxt_st.shin = {st_ff.shin[DATA_W-2:0], st_ff.mosi_s2};
                nxt_st.cnt = st_ff.cnt + SPI_CNT_W'(1);
                if (st_ff.cnt > SPI_CNT_W'(SPI_HDR_LAST)) begin
                    nxt_st.shout = {st_ff.shout[DATA_W-2:0], 1'b0};
                end
                if (st_ff.cnt == SPI_CNT_W'(SPI_HDR_LAST)) begin
                    nxt_st.addr = st_ff.shin[ADDR_W-1:0];
                    nxt_st.wbit = st_ff.mosi_s2;
                    nxt_st.load = ~st_ff.mosi_s2;
                end
                if (st_ff.cnt == SPI_CNT_W'(SPI_FRAME_LAST)) begin
                    nxt_st.wr = st_ff.wbit;
                    nxt_st.wdata = {st_ff.shin[DATA_W-2:0], st_ff.mosi_s2};
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
            st_ff.ss_s1 <= 1'b1;
            st_ff.ss_s2 <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cp.wr = st_ff.wr;
    assign cp.addr = st_ff.addr;
    assign cp.wdata = st_ff.wdata;
    assign spi_miso = st_ff.shout[DATA_W-1];
    assign spi_miso_oe = st_ff.miso_oe;

    // a write strobe is a single cycle
    AST_SPI_WR_PULSE: assert property (@(posedge mclk) disable iff (reset)
        st_ff.wr |=> !st_ff.wr)
        else $error("write strobe longer than one cycle");
endmodule
`default_nettype wire

// [rx_align_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rx_align_model
    import outdp_pkg::*;
(
    input wire logic lclk,
    input wire logic reset,
    input wire logic [NUM_LANES-1:0][WORD_W-1:0] data_word,
    input wire logic [WORD_W-1:0] train,
    output logic locked
);
    logic [3:0] run_ff;
    // every lane must show the alignment word for a run before lock;
    // lock then stays, since frames replace the word with pixels
    always_ff @(posedge lclk or posedge reset) begin
        if (reset) begin
            run_ff <= 4'h0;
        end else if (run_ff != 4'h8) begin
            if (data_word != {NUM_LANES{train}}) begin
                run_ff <= 4'h0;
            end else begin
                run_ff <= run_ff + 4'h1;
            end
        end
    end
    assign locked = (run_ff == 4'h8);
endmodule
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import outdp_pkg::*;
    typedef struct packed {
        logic [8:0] a;
        logic [15:0] rst;
        logic [15:0] wv;
        logic [15:0] rv;
    } row_t;
    logic mclk = 0, lclk = 0, reset = 1;
    logic spi_sck = 0, spi_ss_n = 1, spi_mosi = 0, spi_miso, spi_miso_oe;
    logic frame_active = 0, pix_valid = 0, pix_black = 0, win_id = 0;
    logic [NUM_LANES-1:0][WORD_W-1:0] pix_data = '0, data_word, crc_word;
    logic [WORD_W-1:0] sync_word;
    logic clk_out_en, sync_en, data_en, win_id_out, rx_locked;
    logic [15:0] rd;
    int n_fail = 0, compares = 0, cyc = 0, n;
    // last row is an unmapped address: writes vanish, reads give 0
    row_t rows [6] = '{
        '{REG_SER_PWR, RST_SER_PWR, 16'hfff8, 16'hfff8},
        '{REG_BLACK_CAL, RST_BLACK_CAL, 16'h8a5c, 16'h8a5c},
        '{REG_GEN_CFG, RST_GEN_CFG, 16'h5aa1, 16'h5aa1},
        '{REG_IDLE_WORD, RST_IDLE_WORD, 16'h0155, 16'h0155},
        '{REG_MARKER, RST_MARKER, 16'h0011, 16'h0011},
        '{9'h071, 16'h0000, 16'hffff, 16'h0000}};

    always #12.5 mclk = ~mclk;
    always #3 lclk = ~lclk;

    outdp_top DUT (.mclk, .reset, .lclk, .spi_sck, .spi_ss_n, .spi_mosi,
        .spi_miso, .spi_miso_oe, .frame_active, .pix_valid, .pix_black,
        .pix_data, .win_id, .data_word, .sync_word, .crc_word, .clk_out_en,
        .sync_en, .data_en, .win_id_out);
    rx_align_model rx (.lclk, .reset, .data_word, .train(10'h155),
        .locked(rx_locked));

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // a hung handshake must still reach the verdict
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            conclude;
        end
    end

    task automatic mc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic lc(input int k);
        repeat (k) @(posedge lclk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // sck phases of 6 mclk keep clear of the 4-cycle minimum
    task automatic spi(input logic [8:0] a, input logic w,
                       input logic [15:0] wd);
        logic [25:0] f;
        f = {a, w, wd};
        spi_ss_n = 0;
        mc(6);
        for (int i = 0; i < 26; i++) begin
            spi_mosi = f[25-i];
            mc(6);
            if (i == 10) chk("miso enable", 16'h1, spi_miso_oe);
            if (i >= 10) rd = {rd[14:0], spi_miso};
            spi_sck = 1;
            mc(6);
            spi_sck = 0;
        end
        mc(6);
        spi_ss_n = 1;
        mc(8);
    endtask
    // extra wait lets the setting cross into the link domain
    task automatic cfg(input logic [8:0] a, input logic [15:0] wd);
        spi(a, 1'b1, wd);
        mc(20);
    endtask
    task automatic px(input logic fa, v, b, input logic [9:0] d);
        frame_active = fa;
        pix_valid = v;
        pix_black = b;
        pix_data = {NUM_LANES{d}};
        lc(1);
    endtask
    task automatic wid(input logic [15:0] e);
        win_id = 1;
        lc(1);
        win_id = 0;
        n = 1;
        while (win_id_out !== 1'b1 && n < 20) begin
            lc(1);
            n++;
        end
        chk("window id delay", e, 16'(n));
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        #1 reset = 0;
        mc(4);
        foreach (rows[i]) begin
            spi(rows[i].a, 1'b0, 16'h0);
            chk("reset value", rows[i].rst, rd);
        end
        foreach (rows[i]) begin
            cfg(rows[i].a, rows[i].wv);
            spi(rows[i].a, 1'b0, 16'h0);
            chk("readback", rows[i].rv, rd);
        end
        $display("register rows done");
        for (int k = 0; k < 3; k++) begin
            cfg(REG_SER_PWR, 16'h1 << k);
            chk("power", 16'(3'b100 >> k), {clk_out_en, sync_en, data_en});
            chk("lane word", k == 2 ? 16'h155 : 16'h0, data_word[3]);
        end
        cfg(REG_SER_PWR, 16'h0007);
        for (int l = 0; l < NUM_LANES; l++) begin
            chk("idle word", 16'h155, data_word[l]);
        end
        chk("receiver lock", 16'h1, rx_locked);
        chk("sync idle", 16'h155, sync_word);
        $display("power and idle done");
        cfg(REG_GEN_CFG, 16'h000a);
        px(1, 1, 0, 10'd100);
        chk("add offset", 16'd105, data_word[0]);
        chk("crc seed ones", 16'h3ff, crc_word[0]);
        chk("sync marker", 16'h011, sync_word);
        px(1, 1, 0, 10'd0);
        chk("offset on zero", 16'd5, data_word[0]);
        px(0, 0, 0, 10'd0);
        cfg(REG_GEN_CFG, 16'h040a);
        px(1, 1, 0, 10'd100);
        chk("sub offset", 16'd95, data_word[1]);
        px(0, 0, 0, 10'd0);
        cfg(REG_BLACK_CAL, 16'h0008);
        cfg(REG_GEN_CFG, 16'h040b);
        px(1, 1, 0, 10'd100);
        chk("manual ignored", 16'd100, data_word[2]);
        // one black sample per average: offset is target minus pixel
        px(1, 1, 1, 10'd20);
        px(1, 1, 0, 10'd100);
        chk("single black", 16'd88, data_word[2]);
        px(0, 0, 0, 10'd0);
        cfg(REG_BLACK_CAL, 16'h0108);
        // frame start clears the sums, so black pixels follow it
        px(1, 0, 0, 10'd0);
        chk("crc seed zeros", 16'h000, crc_word[1]);
        px(1, 1, 1, 10'd20);
        px(1, 1, 1, 10'd22);
        px(1, 1, 0, 10'd100);
        chk("auto black", 16'd87, data_word[3]);
        $display("calibration done");
        px(0, 0, 0, 10'd0);
        cfg(REG_GEN_CFG, 16'h0000);
        wid(16'd1);
        cfg(REG_GEN_CFG, 16'h2000);
        // inside a frame, so the window id assertion is exercised too
        frame_active = 1;
        wid(16'd5);
        cfg(REG_GEN_CFG, 16'h000a);
        px(1, 1, 0, 10'd100);
        chk("narrow held in frame", 16'd25, data_word[0]);
        px(0, 0, 0, 10'd0);
        lc(8);
        px(1, 1, 0, 10'd100);
        chk("change after frame", 16'd105, data_word[0]);
        $display("width and timing done");
        px(0, 0, 0, 10'd0);
        reset = 1;
        mc(2);
        chk("reset power", 16'h0, data_en);
        chk("reset lane", 16'h0, data_word[0]);
        reset = 0;
        mc(4);
        spi(REG_SER_PWR, 1'b0, 16'h0);
        chk("power after reset", RST_SER_PWR, rd);
        chk("miso released", 16'h0, spi_miso_oe);
        $display("second reset done");
        conclude;
    end
endmodule
`default_nettype wire
